// [vipu_top.v]
/*
 * Vectored interrupt priority unit: gathers one non-maskable source,
 * twenty maskable sources and the software break, keeps the request
 * flags, picks a winner and offers its vector to the core.
 * Assumes the core holds the global enable, in-service level, mask and
 * priority-level flags and drives them in; all inputs are synchronous.
 */
`default_nettype none
`include "vipu_defines.vh"

module vipu_top (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // watchdog source
    input wire watchdog_overflow_irq,
    input wire watchdog_nmi_mode,
    // external pins, raw levels
    input wire ext_pin_edge_irq_0,
    input wire ext_pin_edge_irq_1,
    input wire ext_pin_edge_irq_2,
    input wire ext_pin_edge_irq_3,
    input wire ext_pin_edge_irq_4,
    input wire ext_pin_edge_irq_5,
    input wire ext_pin_edge_irq_6,
    input wire [`VIPU_EXT_PINS-1:0] ext_edge_rise_en,
    input wire [`VIPU_EXT_PINS-1:0] ext_edge_fall_en,
    // serial channels
    input wire serial0_done_irq,
    input wire serial1_done_irq,
    input wire serial2_rx_error_irq,
    input wire serial2_rx_done_irq,
    input wire serial2_threewire_done_irq,
    input wire serial2_uart_mode,
    input wire serial2_tx_done_irq,
    // timers and converter
    input wire watch_interval_irq,
    input wire wide_timer_match_a_irq,
    input wire wide_timer_match_b_irq,
    input wire narrow_timer_one_match_irq,
    input wire narrow_timer_two_match_irq,
    input wire conversion_done_irq,
    // software break from instruction decode
    input wire software_break,
    // core-held flags
    input wire global_enable_flag,
    input wire in_service_level_flag,
    input wire [`VIPU_NUM_SLOTS-1:0] mask_flag,
    input wire [`VIPU_NUM_SLOTS-1:0] priority_level_flag,
    input wire [`VIPU_NUM_SLOTS-1:0] req_flag_clear,
    // core handshake
    input wire irq_ack,
    output reg irq_request_ff,
    output reg [`VIPU_VEC_W-1:0] irq_vector_ff,
    output reg irq_nonmaskable_ff,
    output reg irq_low_group_ff,
    // flag status
    output reg [`VIPU_NUM_SLOTS-1:0] req_flag_ff,
    output reg nmi_pending_ff,
    output reg break_pending_ff
);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // lowest set index wins; caller checks for any bit set
    function [`VIPU_SLOT_W-1:0] first_set;
        input [`VIPU_NUM_SLOTS-1:0] vec;
        integer i;
        begin
            first_set = `VIPU_SLOT_NONE;
            for (i = `VIPU_NUM_SLOTS - 1; i >= 0; i = i - 1)
            begin
                if (vec[i])
                begin
                    first_set = i[`VIPU_SLOT_W-1:0];
                end
            end
        end
    endfunction

    // slot k sits at base + 2k in the vector table
    function [`VIPU_VEC_W-1:0] slot_vector;
        input [`VIPU_SLOT_W-1:0] slot;
        begin
            slot_vector = `VIPU_VEC_BASE + {10'h000, slot, 1'b0};
        end
    endfunction

    // one-hot mask for a slot number
    function [`VIPU_NUM_SLOTS-1:0] slot_onehot;
        input [`VIPU_SLOT_W-1:0] slot;
        integer i;
        begin
            slot_onehot = {`VIPU_NUM_SLOTS{1'b0}};
            for (i = 0; i < `VIPU_NUM_SLOTS; i = i + 1)
            begin
                if (slot == i[`VIPU_SLOT_W-1:0])
                begin
                    slot_onehot[i] = 1'b1;
                end
            end
        end
    endfunction

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    wire [`VIPU_EXT_PINS-1:0] ext_levels;
    wire [`VIPU_EXT_PINS-1:0] ext_edges;
    reg [`VIPU_NUM_SLOTS-1:0] slot_set;
    reg nmi_set;
    reg [`VIPU_SLOT_W-1:0] grant_slot_ff;
    reg grant_nmi_ff;
    reg grant_break_ff;
    wire ack_taken;
    wire [`VIPU_NUM_SLOTS-1:0] ack_clear;
    wire [`VIPU_NUM_SLOTS-1:0] nxt_req_flag;
    wire nxt_nmi_pending;
    wire nxt_break_pending;
    wire [`VIPU_NUM_SLOTS-1:0] eligible;
    wire [`VIPU_NUM_SLOTS-1:0] high_group;
    wire [`VIPU_NUM_SLOTS-1:0] low_group;
    reg nxt_irq_request;
    reg [`VIPU_VEC_W-1:0] nxt_irq_vector;
    reg nxt_irq_nonmaskable;
    reg nxt_irq_low_group;
    reg [`VIPU_SLOT_W-1:0] nxt_grant_slot;
    reg nxt_grant_nmi;
    reg nxt_grant_break;

    // ----------------------------------------
    // external pin edge detection
    // ----------------------------------------
    assign ext_levels = {ext_pin_edge_irq_6, ext_pin_edge_irq_5, ext_pin_edge_irq_4, ext_pin_edge_irq_3,
                         ext_pin_edge_irq_2, ext_pin_edge_irq_1, ext_pin_edge_irq_0};

    vipu_edge_detect #(
        .PINS(`VIPU_EXT_PINS)
    ) u_edge (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pin_level(ext_levels),
        .rise_en(ext_edge_rise_en),
        .fall_en(ext_edge_fall_en),
        .edge_pulse(ext_edges)
    );

    // ----------------------------------------
    // source to slot mapping
    // ----------------------------------------
    // every maskable source lands in a slot whose index is its default priority
    always @*
    begin
        slot_set = {`VIPU_NUM_SLOTS{1'b0}};
        nmi_set = 1'b0;
        if (watchdog_nmi_mode)
        begin
            nmi_set = watchdog_overflow_irq;
        end
        else
        begin
            slot_set[`VIPU_SLOT_WDT] = watchdog_overflow_irq;
        end
        slot_set[`VIPU_SLOT_EXT0 +: `VIPU_EXT_PINS] = ext_edges;
        slot_set[`VIPU_SLOT_SER0] = serial0_done_irq;
        slot_set[`VIPU_SLOT_SER1] = serial1_done_irq;
        slot_set[`VIPU_SLOT_SER2_ERR] = serial2_rx_error_irq;
        // the idle mode's completion is ignored, so a stale event cannot fire
        slot_set[`VIPU_SLOT_SER2_RX] = serial2_uart_mode ? serial2_rx_done_irq : serial2_threewire_done_irq;
        slot_set[`VIPU_SLOT_SER2_TX] = serial2_tx_done_irq;
        slot_set[`VIPU_SLOT_WATCH] = watch_interval_irq;
        slot_set[`VIPU_SLOT_WIDE_A] = wide_timer_match_a_irq;
        slot_set[`VIPU_SLOT_WIDE_B] = wide_timer_match_b_irq;
        slot_set[`VIPU_SLOT_NARROW1] = narrow_timer_one_match_irq;
        slot_set[`VIPU_SLOT_NARROW2] = narrow_timer_two_match_irq;
        slot_set[`VIPU_SLOT_CONV] = conversion_done_irq;
    end

    // ----------------------------------------
    // request flags
    // ----------------------------------------
    assign ack_taken = irq_ack & irq_request_ff;
    assign ack_clear = (ack_taken & ~grant_nmi_ff & ~grant_break_ff) ?
        slot_onehot(grant_slot_ff) : {`VIPU_NUM_SLOTS{1'b0}};

    // a set in the same cycle as a clear wins
    assign nxt_req_flag = (req_flag_ff & ~ack_clear & ~req_flag_clear) | slot_set;
    assign nxt_nmi_pending = (nmi_pending_ff & ~(ack_taken & grant_nmi_ff)) | nmi_set;
    assign nxt_break_pending = (break_pending_ff & ~(ack_taken & grant_break_ff)) | software_break;

    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    // judged on next-state flags so an acknowledged source is never re-offered
    assign eligible = nxt_req_flag & ~mask_flag & {`VIPU_NUM_SLOTS{global_enable_flag}};
    assign high_group = eligible & ~priority_level_flag;
    // low group waits while a high-group handler is in service
    assign low_group = eligible & priority_level_flag & {`VIPU_NUM_SLOTS{in_service_level_flag}};

    // 1 unmaskable + 20 maskable in 19 slots + 1 software = all sources
    always @*
    begin
        nxt_irq_request = 1'b0;
        nxt_irq_vector = `VIPU_VEC_NONE;
        nxt_irq_nonmaskable = 1'b0;
        nxt_irq_low_group = 1'b0;
        nxt_grant_slot = `VIPU_SLOT_NONE;
        nxt_grant_nmi = 1'b0;
        nxt_grant_break = 1'b0;
        if (nxt_nmi_pending)
        begin
            nxt_irq_request = 1'b1;
            nxt_irq_vector = `VIPU_VEC_NMI;
            nxt_irq_nonmaskable = 1'b1;
            nxt_grant_nmi = 1'b1;
        end
        else if (nxt_break_pending)
        begin
            nxt_irq_request = 1'b1;
            nxt_irq_vector = `VIPU_VEC_BREAK;
            nxt_irq_nonmaskable = 1'b1;
            nxt_grant_break = 1'b1;
        end
        else if (|high_group)
        begin
            nxt_irq_request = 1'b1;
            nxt_grant_slot = first_set(high_group);
            nxt_irq_vector = slot_vector(first_set(high_group));
        end
        else if (|low_group)
        begin
            nxt_irq_request = 1'b1;
            nxt_grant_slot = first_set(low_group);
            nxt_irq_vector = slot_vector(first_set(low_group));
            nxt_irq_low_group = 1'b1;
        end
    end

    // ----------------------------------------
    // state and output registers
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            req_flag_ff <= {`VIPU_NUM_SLOTS{1'b0}};
            nmi_pending_ff <= 1'b0;
            break_pending_ff <= 1'b0;
            irq_request_ff <= 1'b0;
            irq_vector_ff <= `VIPU_VEC_NONE;
            irq_nonmaskable_ff <= 1'b0;
            irq_low_group_ff <= 1'b0;
            grant_slot_ff <= `VIPU_SLOT_NONE;
            grant_nmi_ff <= 1'b0;
            grant_break_ff <= 1'b0;
        end
        else
        begin
            req_flag_ff <= nxt_req_flag;
            nmi_pending_ff <= nxt_nmi_pending;
            break_pending_ff <= nxt_break_pending;
            irq_request_ff <= nxt_irq_request;
            irq_vector_ff <= nxt_irq_vector;
            irq_nonmaskable_ff <= nxt_irq_nonmaskable;
            irq_low_group_ff <= nxt_irq_low_group;
            grant_slot_ff <= nxt_grant_slot;
            grant_nmi_ff <= nxt_grant_nmi;
            grant_break_ff <= nxt_grant_break;
        end
    end

endmodule

`default_nettype wire

// [vipu_defines.vh]
/*
 * Constants shared by the vectored interrupt priority unit: slot numbers,
 * vector table addresses, source counts and field widths.
 * Assumes inclusion by bare name from the unit's design files.
 */
`ifndef VIPU_DEFINES_VH
`define VIPU_DEFINES_VH

// ----------------------------------------
// source counts and widths
// ----------------------------------------
`define VIPU_NUM_SOURCES 22
`define VIPU_NUM_MASKABLE 20
`define VIPU_NUM_SLOTS 19
`define VIPU_SLOT_W 5
`define VIPU_EXT_PINS 7
`define VIPU_VEC_W 16

// ----------------------------------------
// vector table addresses
// ----------------------------------------
`define VIPU_VEC_NMI 16'h0004
`define VIPU_VEC_BREAK 16'h003e
`define VIPU_VEC_BASE 16'h0004
`define VIPU_VEC_NONE 16'h0000

// ----------------------------------------
// maskable slots, index equals default priority
// ----------------------------------------
`define VIPU_SLOT_WDT 5'h00
`define VIPU_SLOT_EXT0 5'h01
`define VIPU_SLOT_SER0 5'h08
`define VIPU_SLOT_SER1 5'h09
`define VIPU_SLOT_SER2_ERR 5'h0a
`define VIPU_SLOT_SER2_RX 5'h0b
`define VIPU_SLOT_SER2_TX 5'h0c
`define VIPU_SLOT_WATCH 5'h0d
`define VIPU_SLOT_WIDE_A 5'h0e
`define VIPU_SLOT_WIDE_B 5'h0f
`define VIPU_SLOT_NARROW1 5'h10
`define VIPU_SLOT_NARROW2 5'h11
`define VIPU_SLOT_CONV 5'h12
`define VIPU_SLOT_NONE 5'h1f

`endif

// [vipu_edge_detect.v]
/*
 * Edge detector for the external interrupt pins: each pin can fire on a
 * rising edge, a falling edge, or both.
 * Assumes pin levels already synchronous to ref_clk.
 */
`default_nettype none

module vipu_edge_detect #(
    parameter PINS = 7
) (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // pins and edge selection
    input wire [PINS-1:0] pin_level,
    input wire [PINS-1:0] rise_en,
    input wire [PINS-1:0] fall_en,
    // one-cycle edge pulses
    output reg [PINS-1:0] edge_pulse
);

    reg [PINS-1:0] prev_ff;
    reg primed_ff;
    wire [PINS-1:0] nxt_edge_pulse;

    // ----------------------------------------
    // edge compare
    // ----------------------------------------
    // first cycle after reset only samples, so a pin already high is no edge
    assign nxt_edge_pulse = primed_ff ?
        ((pin_level & ~prev_ff & rise_en) | (~pin_level & prev_ff & fall_en)) : {PINS{1'b0}};

    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            prev_ff <= {PINS{1'b0}};
            primed_ff <= 1'b0;
            edge_pulse <= {PINS{1'b0}};
        end
        else
        begin
            prev_ff <= pin_level;
            primed_ff <= 1'b1;
            edge_pulse <= nxt_edge_pulse;
        end
    end

endmodule

`default_nettype wire

// [vipu_monitor.sv]
/* Checker for vipu_top: offer, flag and ack relations.
   Assumes a bind onto vipu_top and one clock domain. */
`default_nettype none
module vipu_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // sources
    input wire logic watchdog_overflow_irq,
    input wire logic watchdog_nmi_mode,
    input wire logic serial0_done_irq,
    input wire logic software_break,
    // core flags and ack
    input wire logic global_enable_flag,
    input wire logic [18:0] mask_flag,
    input wire logic [18:0] priority_level_flag,
    input wire logic irq_ack,
    // watched outputs
    input wire logic irq_request_ff,
    input wire logic [15:0] irq_vector_ff,
    input wire logic irq_nonmaskable_ff,
    input wire logic irq_low_group_ff,
    input wire logic [18:0] req_flag_ff,
    input wire logic nmi_pending_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------
    // gating as sampled at the offer edge
    // ------
    logic enable_ff;
    logic [18:0] mask_ff;
    logic [18:0] lvl_ff;
    always_ff @(posedge ref_clk)
    begin
        enable_ff <= global_enable_flag;
        mask_ff <= mask_flag;
        lvl_ff <= priority_level_flag;
    end
    wire logic [15:0] slot_w = (irq_vector_ff - 16'h0004) >> 1;
    wire logic [18:0] below_w = (19'h1 << slot_w[4:0]) - 19'h1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence seq_nmi_fire;
        watchdog_overflow_irq && watchdog_nmi_mode;
    endsequence
    sequence seq_offer_mask;
        irq_request_ff && !irq_nonmaskable_ff;
    endsequence
    // ------
    // properties
    // ------
    chk_nmi_raise: assert property (seq_nmi_fire |=> irq_nonmaskable_ff && irq_vector_ff == 16'h0004)
        else $error("nmi not offered");
    chk_wdt_slot: assert property (watchdog_overflow_irq && !watchdog_nmi_mode |=> req_flag_ff[0])
        else $error("interval overflow flag missing");
    chk_ser0_flag: assert property (serial0_done_irq |=> req_flag_ff[8])
        else $error("serial0 flag missing");
    chk_break_vec: assert property (software_break && !nmi_pending_ff && !(watchdog_overflow_irq
        && watchdog_nmi_mode) |=> irq_vector_ff == 16'h003e)
        else $error("break vector wrong");
    chk_offer_gated: assert property (seq_offer_mask |-> !irq_vector_ff[0] && slot_w < 16'd19
        && req_flag_ff[slot_w[4:0]] && enable_ff && !mask_ff[slot_w[4:0]])
        else $error("offer not pending or gated");
    chk_pick_lowest: assert property (seq_offer_mask ##0 !irq_low_group_ff |->
        (req_flag_ff & ~mask_ff & ~lvl_ff & below_w) == 19'h0)
        else $error("lower slot passed over");
    chk_ack_clear: assert property (irq_ack && irq_request_ff && irq_vector_ff == 16'h0014
        && !serial0_done_irq |=> !req_flag_ff[8])
        else $error("acked flag not cleared");
    chk_nmi_ack: assert property (irq_ack && irq_nonmaskable_ff && irq_vector_ff == 16'h0004
        && !watchdog_overflow_irq |=> !nmi_pending_ff)
        else $error("nmi flag not cleared");
    chk_idle_zero: assert property (!irq_request_ff |-> irq_vector_ff == 16'h0000)
        else $error("vector shown without offer");
endmodule
bind vipu_top vipu_monitor mon_u (.ref_clk, .nrst, .watchdog_overflow_irq, .watchdog_nmi_mode,
    .serial0_done_irq, .software_break, .global_enable_flag, .mask_flag, .priority_level_flag,
    .irq_ack, .irq_request_ff, .irq_vector_ff, .irq_nonmaskable_ff, .irq_low_group_ff,
    .req_flag_ff, .nmi_pending_ff);
`default_nettype wire

// [vipu_core_model.sv]
/* Core stand-in: acks offers promptly or after a random wait.
   Assumes the vipu_top handshake; records what it took. */
`default_nettype none
module vipu_core_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // offer
    input wire logic irq_request_ff,
    input wire logic [15:0] irq_vector_ff,
    // bench control
    input wire logic ack_en,
    input wire logic slow,
    // ack and record
    output logic ack_ff,
    output logic [15:0] taken_vec_ff,
    output logic [7:0] taken_cnt_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_ff;
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            ack_ff <= 1'b0;
            wait_ff <= 2'h0;
            taken_cnt_ff <= 8'h0;
            taken_vec_ff <= 16'h0;
        end
        else if (ack_ff && irq_request_ff)
        begin
            // vector read together with the ack
            ack_ff <= 1'b0;
            taken_vec_ff <= irq_vector_ff;
            taken_cnt_ff <= taken_cnt_ff + 8'h1;
            wait_ff <= slow ? 2'($urandom) : 2'h0;
        end
        else if (wait_ff != 2'h0)
            wait_ff <= wait_ff - 2'h1;
        else if (ack_en && irq_request_ff)
            ack_ff <= 1'b1;
    end
endmodule
`default_nettype wire

// [tb_vectored_interrupt_priority_unit.sv]
/* Self-checking bench for vipu_top with the core stand-in.
   Assumes vipu_monitor is bound in; inputs move on falling edges. */
`default_nettype none
module tb_vectored_interrupt_priority_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic wdt = 1'b0, nmi_mode = 1'b0, uart = 1'b1, sw_break = 1'b0, gl_en = 1'b1, isl = 1'b1;
    logic ack_en = 1'b0, slow = 1'b0, rx = 1'b0, tw = 1'b0;
    logic [18:0] pulse = 19'h0, mask = 19'h0, clr = 19'h0, lvl = 19'h0, set;
    logic [6:0] pins = 7'h0, rise = 7'h7f, fall = 7'h0;
    logic [7:0] cnt0;
    int num_errors = 0, checks = 0, n, seed;
    wire logic irq_ack, irq_request_ff, irq_nonmaskable_ff, irq_low_group_ff, nmi_pending_ff, break_pending_ff;
    wire logic [15:0] irq_vector_ff, taken_vec;
    wire logic [7:0] taken_cnt;
    wire logic [18:0] req_flag_ff;
    always #25 ref_clk = ~ref_clk;
    vipu_top dut_u (.ref_clk, .nrst, .watchdog_overflow_irq(wdt | pulse[0]), .watchdog_nmi_mode(nmi_mode),
        .ext_pin_edge_irq_0(pins[0]), .ext_pin_edge_irq_1(pins[1]), .ext_pin_edge_irq_2(pins[2]),
        .ext_pin_edge_irq_3(pins[3]), .ext_pin_edge_irq_4(pins[4]), .ext_pin_edge_irq_5(pins[5]),
        .ext_pin_edge_irq_6(pins[6]), .ext_edge_rise_en(rise), .ext_edge_fall_en(fall),
        .serial0_done_irq(pulse[8]), .serial1_done_irq(pulse[9]), .serial2_rx_error_irq(pulse[10]),
        .serial2_rx_done_irq(rx | (pulse[11] & uart)), .serial2_threewire_done_irq(tw | (pulse[11] & ~uart)),
        .serial2_uart_mode(uart), .serial2_tx_done_irq(pulse[12]), .watch_interval_irq(pulse[13]),
        .wide_timer_match_a_irq(pulse[14]), .wide_timer_match_b_irq(pulse[15]),
        .narrow_timer_one_match_irq(pulse[16]), .narrow_timer_two_match_irq(pulse[17]),
        .conversion_done_irq(pulse[18]), .software_break(sw_break), .global_enable_flag(gl_en),
        .in_service_level_flag(isl), .mask_flag(mask), .priority_level_flag(lvl), .req_flag_clear(clr),
        .irq_ack, .irq_request_ff, .irq_vector_ff, .irq_nonmaskable_ff, .irq_low_group_ff,
        .req_flag_ff, .nmi_pending_ff, .break_pending_ff);
    vipu_core_model core_u (.ref_clk, .nrst, .irq_request_ff, .irq_vector_ff, .ack_en, .slow,
        .ack_ff(irq_ack), .taken_vec_ff(taken_vec), .taken_cnt_ff(taken_cnt));
    // ------
    // helpers
    // ------
    function automatic logic [18:0] first_vec(input logic [18:0] v);
        first_vec = 19'h0;
        for (int i = 18; i >= 0; i--)
            if (v[i])
                first_vec = 19'h4 + 19'(2 * i);
    endfunction
    task automatic tick(input int k = 1);
        repeat (k) @(negedge ref_clk);
    endtask
    task automatic stop_test;
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic fire(input logic [18:0] v);
        pulse = v;
        tick();
        pulse = 19'h0;
        tick();
    endtask
    // bounded: a stuck offer ends the run
    task automatic wait_idle;
        for (n = 0; n < 400 && irq_request_ff !== 1'b0; n++)
            tick();
        if (n == 400)
        begin
            num_errors++;
            stop_test();
        end
    endtask
    task automatic clear_all;
        clr = 19'h7ffff;
        tick();
        clr = 19'h0;
    endtask
    // ------
    // main sequence
    // ------
    initial
    begin
        seed = $urandom(48);
        tick(10);
        nrst = 1'b1;
        tick(2);
        for (int k = 0; k < 19; k++)
        begin
            if (k >= 1 && k <= 7)
                pins[k - 1] = 1'b1;
            fire((k >= 1 && k <= 7) ? 19'h0 : 19'h1 << k);
            tick();
            check({3'h0, irq_vector_ff}, first_vec(19'h1 << k));
            pins = 7'h0;
            clear_all();
            tick(3);
            check(req_flag_ff, 19'h0);
        end
        // falling edge on one pin only, rising edges switched off
        rise = 7'h00;
        fall = 7'h04;
        pins = 7'h7f;
        tick(3);
        check(req_flag_ff, 19'h0);
        pins = 7'h7b;
        tick(3);
        check({3'h0, irq_vector_ff}, first_vec(19'h1 << 3));
        pins = 7'h00;
        rise = 7'h7f;
        fall = 7'h00;
        clear_all();
        for (int m = 0; m < 2; m++)
        begin
            uart = m[0];
            {rx, tw} = m[0] ? 2'b01 : 2'b10;
            tick();
            {rx, tw} = 2'b00;
            tick();
            check(19'(req_flag_ff[11]), 19'h0);
            {rx, tw} = m[0] ? 2'b10 : 2'b01;
            tick();
            {rx, tw} = 2'b00;
            tick();
            check(19'(req_flag_ff[11]), 19'h1);
            clear_all();
        end
        // early rounds unmasked so ack order is pure priority
        for (int r = 0; r < 24; r++)
        begin
            set = 19'($urandom) & 19'h7ff01;
            mask = (r < 4) ? 19'h0 : 19'($urandom);
            slow = 1'($urandom);
            cnt0 = taken_cnt;
            fire(set);
            check({3'h0, irq_vector_ff}, first_vec(set & ~mask));
            ack_en = 1'b1;
            wait_idle();
            ack_en = 1'b0;
            check(19'(taken_cnt - cnt0), 19'($countones(set & ~mask)));
            check(req_flag_ff, set & mask);
            mask = 19'h0;
            clear_all();
        end
        // high group beats low group; low group held off at in-service level 0
        lvl = 19'h1 << 8;
        fire((19'h1 << 8) | (19'h1 << 14));
        check({3'h0, irq_vector_ff}, first_vec(19'h1 << 14));
        check(19'(irq_low_group_ff), 19'h0);
        clr = 19'h1 << 14;
        tick();
        clr = 19'h0;
        check({3'h0, irq_vector_ff}, first_vec(19'h1 << 8));
        check(19'(irq_low_group_ff), 19'h1);
        isl = 1'b0;
        tick();
        check(19'(irq_request_ff), 19'h0);
        isl = 1'b1;
        lvl = 19'h0;
        clear_all();
        // set and clear in one cycle: set wins
        pulse = 19'h1 << 9;
        clr = 19'h1 << 9;
        tick();
        {pulse, clr} = 38'h0;
        tick();
        check(19'(req_flag_ff[9]), 19'h1);
        clear_all();
        gl_en = 1'b0;
        fire(19'h1 << 13);
        check(19'(irq_request_ff), 19'h0);
        nmi_mode = 1'b1;
        wdt = 1'b1;
        sw_break = 1'b1;
        tick();
        wdt = 1'b0;
        sw_break = 1'b0;
        tick();
        check({3'h0, irq_vector_ff}, 19'h4);
        check(19'({irq_nonmaskable_ff, break_pending_ff}), 19'h3);
        cnt0 = taken_cnt;
        ack_en = 1'b1;
        wait_idle();
        check({3'h0, taken_vec}, 19'h3e);
        check(19'(taken_cnt - cnt0), 19'h2);
        check(19'({nmi_pending_ff, break_pending_ff}), 19'h0);
        gl_en = 1'b1;
        tick(2);
        wait_idle();
        check(req_flag_ff, 19'h0);
        stop_test();
    end
endmodule
`default_nettype wire
